// ===== verilog/sdcmd_top.sv
// Purpose: Command decoder and clock-enable state handling of the memory device
// Assumes: Controller keeps its own timing duties; pins synchronous to clk_sys
// Notes:   Array, data path and drivers are outside this block
//
// What this block does
// - Low select, high RAS/CAS/WE decodes no-op
// - No-op or deselect never stops a burst
// - High select ignores RAS/CAS/WE, acts as no-op
// - Bank lines pick bank or mode register
// - A10 picks auto-precharge or precharge-all
// - Refresh with clock enable falling and no bank open enters self-refresh
// - Burst of four runs to completion unless a new read or write restarts it
// - No refresh performed during power-down
// - Termination input ignored by state; off in self-refresh
// - Power-down entry/exit only with no-op or deselect
// - Decision uses current, previous enable and state
// - Falling enable enters precharge or active power-down
// - Self-refresh exit on rise, then only no-ops
// - Controller waits power-down exit latency
// - High data mask blocks that write beat

`timescale 1ns/100ps

module sdcmd_top
  import sdcmd_pkg::*;
#(
  parameter int NONREAD_CLKS = EXIT_NONREAD_DELAY_CLKS,
  parameter int READ_CLKS    = EXIT_READ_DELAY_CLKS
)
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Command pins
  input  wire logic              cke,
  input  wire logic              cs_n,
  input  wire logic              ras_n,
  input  wire logic              cas_n,
  input  wire logic              we_n,
  input  wire logic [BANK_W-1:0] ba,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              odt,
  input  wire logic              dm,
  // Decoded operations
  output logic                   mrs_pulse_reg,
  output logic [BANK_W-1:0]      mrs_sel_reg,
  output logic [ADDR_W-1:0]      mrs_opcode_reg,
  output logic                   refresh_pulse_reg,
  output logic                   act_pulse_reg,
  output logic [ADDR_W-1:0]      act_row_reg,
  output logic                   rd_pulse_reg,
  output logic                   wr_pulse_reg,
  output logic                   auto_pre_reg,
  output logic                   pre_pulse_reg,
  output logic                   pre_all_reg,
  output logic [BANK_W-1:0]      bank_reg,
  output logic                   write_beat_en_reg,
  // Status
  output logic [NUM_BANKS-1:0]   bank_open_reg,
  output logic                   burst_busy_reg,
  output sdcmd_pstate_t          pstate_reg,
  output logic                   odt_active_reg,
  output logic                   read_allowed_reg,
  output logic                   illegal_cmd_reg
);

  // ****************************************
  // Parameter checks
  // ****************************************
  initial begin
    if (READ_CLKS < NONREAD_CLKS) $error("read exit must not be shorter than non-read");
    if (READ_CLKS >= (1 << CNT_W)) $error("exit count exceeds counter width");
  end

  // ****************************************
  // Decode
  // ****************************************
  sdcmd_dec_if dif ();
  assign dif.cs_n  = cs_n;
  assign dif.ras_n = ras_n;
  assign dif.cas_n = cas_n;
  assign dif.we_n  = we_n;
  assign dif.addr  = addr;

  sdcmd_pin_decode u_dec (
    .d (dif.dec)
  );

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic                cke_prev;
    sdcmd_pstate_t       pst;
    logic [CNT_W-1:0]    exit_cnt;
    logic [1:0]          burst_cnt;
    logic                burst_ap;
    logic [BANK_W-1:0]   burst_bank;
    logic                burst_wr;
    logic                mrs_p;
    logic [BANK_W-1:0]   mrs_sel;
    logic [ADDR_W-1:0]   mrs_op;
    logic                ref_p;
    logic                act_p;
    logic [ADDR_W-1:0]   row;
    logic                rd_p;
    logic                wr_p;
    logic                ap;
    logic                pre_p;
    logic                pre_all;
    logic [BANK_W-1:0]   bank;
    logic                wbeat;
    logic                odt_act;
    logic                illegal;
  } sdcmd_st_t;

  sdcmd_st_t s_reg;
  sdcmd_st_t s_next;

  logic [NUM_BANKS-1:0] open_w;
  logic                 ap_done;
  logic                 quiet;
  logic                 powered;
  logic                 any_open;

  assign quiet    = (dif.cmd == SDCMD_NOP) || (dif.cmd == SDCMD_DESEL);
  assign powered  = (s_reg.pst == SDCMD_ST_IDLE) || (s_reg.pst == SDCMD_ST_ACTIVE);
  assign any_open = |open_w;
  assign ap_done  = (s_reg.burst_cnt == 2'h1) && s_reg.burst_ap;

  // Next-state logic
  always_comb begin
    s_next          = s_reg;
    s_next.cke_prev = cke;
    s_next.mrs_p    = 1'b0;
    s_next.ref_p    = 1'b0;
    s_next.act_p    = 1'b0;
    s_next.rd_p     = 1'b0;
    s_next.wr_p     = 1'b0;
    s_next.pre_p    = 1'b0;
    s_next.illegal  = 1'b0;
    s_next.wbeat    = 1'b0;
    // Burst counter runs regardless of no-op or deselect
    if (s_reg.burst_cnt != 2'h0) s_next.burst_cnt = s_reg.burst_cnt - 2'h1;
    // Write beat strobe, mask blocks the beat
    if (s_reg.burst_cnt != 2'h0 && s_reg.burst_wr) s_next.wbeat = !dm;
    // Clock enable transition table, termination not consulted
    unique case (s_reg.pst)
      SDCMD_ST_IDLE, SDCMD_ST_ACTIVE: begin
        if (s_reg.cke_prev && !cke) begin
          if (dif.cmd == SDCMD_REF && !any_open) begin
            s_next.pst = SDCMD_ST_SREF;
          end else if (quiet) begin
            s_next.pst = any_open ? SDCMD_ST_APD : SDCMD_ST_PPD;
          end else begin
            s_next.illegal = 1'b1;
          end
        end else if (s_reg.cke_prev && cke) begin
          unique case (dif.cmd)
            SDCMD_MRS: begin
              s_next.mrs_p   = 1'b1;
              s_next.mrs_sel = ba;
              s_next.mrs_op  = addr;
            end
            SDCMD_REF: s_next.ref_p = 1'b1;
            SDCMD_ACT: begin
              s_next.act_p = 1'b1;
              s_next.row   = addr;
              s_next.bank  = ba;
            end
            SDCMD_RD, SDCMD_WR: begin
              s_next.rd_p       = (dif.cmd == SDCMD_RD);
              s_next.wr_p       = (dif.cmd == SDCMD_WR);
              s_next.ap         = dif.a10;
              s_next.bank       = ba;
              s_next.burst_cnt  = 2'(BURST_CYCLES);
              s_next.burst_ap   = dif.a10;
              s_next.burst_bank = ba;
              s_next.burst_wr   = (dif.cmd == SDCMD_WR);
            end
            SDCMD_PRE: begin
              s_next.pre_p   = 1'b1;
              s_next.pre_all = dif.a10;
              s_next.bank    = ba;
            end
            SDCMD_ILLEGAL: s_next.illegal = 1'b1;
            default: ;
          endcase
        end
        if (s_next.pst == SDCMD_ST_IDLE || s_next.pst == SDCMD_ST_ACTIVE) begin
          s_next.pst = (|open_w || s_next.act_p) ? SDCMD_ST_ACTIVE : SDCMD_ST_IDLE;
        end
      end
      SDCMD_ST_PPD, SDCMD_ST_APD: begin
        // No refresh issued while powered down
        if (!s_reg.cke_prev && cke) begin
          if (quiet) s_next.pst = any_open ? SDCMD_ST_ACTIVE : SDCMD_ST_IDLE;
          else s_next.illegal = 1'b1;
        end
      end
      SDCMD_ST_SREF: begin
        if (!s_reg.cke_prev && cke) begin
          if (quiet) begin
            s_next.pst      = SDCMD_ST_SRX;
            s_next.exit_cnt = '0;
          end else begin
            s_next.illegal = 1'b1;
          end
        end
      end
      SDCMD_ST_SRX: begin
        if (s_reg.exit_cnt != CNT_W'(READ_CLKS)) s_next.exit_cnt = s_reg.exit_cnt + 1'b1;
        if (s_reg.exit_cnt < CNT_W'(NONREAD_CLKS) && !quiet) s_next.illegal = 1'b1;
        if (s_reg.exit_cnt >= CNT_W'(NONREAD_CLKS) - 1'b1) s_next.pst = SDCMD_ST_IDLE;
      end
      default: s_next.pst = SDCMD_ST_IDLE;
    endcase
    // Termination disabled in self-refresh
    s_next.odt_act = odt && (s_next.pst != SDCMD_ST_SREF);
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_reg     <= '0;
      s_reg.pst <= SDCMD_ST_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // Bank open tracker
  sdcmd_bank_track #(
    .NB (NUM_BANKS)
  ) u_banks (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .act_pulse (s_next.act_p),
    .pre_pulse (s_next.pre_p),
    .pre_all   (s_next.pre_all),
    .ap_done   (ap_done),
    .bank      (ba),
    .ap_bank   (s_reg.burst_bank),
    .open_reg  (open_w)
  );

  // Outputs from flops; burst busy and read allowed are decoded from state flops
  assign mrs_pulse_reg     = s_reg.mrs_p;
  assign mrs_sel_reg       = s_reg.mrs_sel;
  assign mrs_opcode_reg    = s_reg.mrs_op;
  assign refresh_pulse_reg = s_reg.ref_p;
  assign act_pulse_reg     = s_reg.act_p;
  assign act_row_reg       = s_reg.row;
  assign rd_pulse_reg      = s_reg.rd_p;
  assign wr_pulse_reg      = s_reg.wr_p;
  assign auto_pre_reg      = s_reg.ap;
  assign pre_pulse_reg     = s_reg.pre_p;
  assign pre_all_reg       = s_reg.pre_all;
  assign bank_reg          = s_reg.bank;
  assign write_beat_en_reg = s_reg.wbeat;
  assign bank_open_reg     = open_w;
  assign burst_busy_reg    = (s_reg.burst_cnt != 2'h0);
  assign pstate_reg        = s_reg.pst;
  assign odt_active_reg    = s_reg.odt_act;
  assign read_allowed_reg  = powered;
  assign illegal_cmd_reg   = s_reg.illegal;

  // ****************************************
  // Checks
  // ****************************************
  property p_nop_no_cmd;
    @(posedge clk_sys) disable iff (rst)
      (s_reg.pst == SDCMD_ST_ACTIVE && s_reg.cke_prev && cke && quiet) |=>
        !(rd_pulse_reg || wr_pulse_reg || act_pulse_reg || pre_pulse_reg);
  endproperty
  a_nop_no_cmd: assert property (p_nop_no_cmd) else $error("no-op produced a command");

  property p_sref_entry;
    @(posedge clk_sys) disable iff (rst)
      (powered && s_reg.cke_prev && !cke && dif.cmd == SDCMD_REF && open_w == '0) |=>
        (pstate_reg == SDCMD_ST_SREF);
  endproperty
  a_sref_entry: assert property (p_sref_entry) else $error("self-refresh not entered");

  sequence s_burst_start;
    (powered && s_reg.cke_prev && cke && (dif.cmd == SDCMD_RD || dif.cmd == SDCMD_WR));
  endsequence
  property p_burst_runs;
    @(posedge clk_sys) disable iff (rst)
      s_burst_start |=> burst_busy_reg [*2] ##1 !burst_busy_reg;
  endproperty
  a_burst_runs: assert property (p_burst_runs) else $error("burst not two cycles");

  property p_pd_kind;
    @(posedge clk_sys) disable iff (rst)
      (powered && s_reg.cke_prev && !cke && quiet) |=>
        (pstate_reg == ($past(open_w) != '0 ? SDCMD_ST_APD : SDCMD_ST_PPD));
  endproperty
  a_pd_kind: assert property (p_pd_kind) else $error("wrong power-down kind");

  property p_pd_hold;
    @(posedge clk_sys) disable iff (rst)
      ((s_reg.pst == SDCMD_ST_PPD || s_reg.pst == SDCMD_ST_APD) && !cke) |=>
        ($stable(pstate_reg) && !refresh_pulse_reg);
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("power-down not kept");

  property p_odt_sref;
    @(posedge clk_sys) disable iff (rst)
      (pstate_reg == SDCMD_ST_SREF) |-> !odt_active_reg;
  endproperty
  a_odt_sref: assert property (p_odt_sref) else $error("termination on in self-refresh");

  property p_a10_pre;
    @(posedge clk_sys) disable iff (rst)
      (powered && s_reg.cke_prev && cke && dif.cmd == SDCMD_PRE) |=>
        (pre_all_reg == $past(addr[A10_POS]) && bank_reg == $past(ba));
  endproperty
  a_a10_pre: assert property (p_a10_pre) else $error("precharge variant wrong");

  property p_cke_prev;
    @(posedge clk_sys) disable iff (rst)
      (s_reg.pst == SDCMD_ST_SREF && !cke) ##1 cke |=> (pstate_reg != SDCMD_ST_SREF) || illegal_cmd_reg;
  endproperty
  a_cke_prev: assert property (p_cke_prev) else $error("self-refresh exit missed");

  property p_mask;
    @(posedge clk_sys) disable iff (rst)
      (burst_busy_reg && dm) |=> !write_beat_en_reg;
  endproperty
  a_mask: assert property (p_mask) else $error("masked beat written");

endmodule

// ===== verilog/sdcmd_pkg.sv
// Purpose: Shared constants and types for the command and clock-enable decoder
// Assumes: Four banks, single clock, pins sampled on the rising edge
// Notes:   Timing counts are in clock cycles

package sdcmd_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int BANK_W      = 2;
  localparam int ADDR_W      = 13;
  localparam int A10_POS     = 10;
  localparam int NUM_BANKS   = 4;

  // ****************************************
  // Timing counts
  // ****************************************
  localparam int BURST_LENGTH_BEATS    = 4;
  localparam int BURST_CYCLES          = BURST_LENGTH_BEATS / 2;
  localparam int EXIT_READ_DELAY_CLKS  = 200;
  localparam int EXIT_NONREAD_DELAY_CLKS = 10;
  localparam int CNT_W                 = 8;

  // ****************************************
  // Decoded commands
  // ****************************************
  typedef enum logic [3:0] {
    SDCMD_NOP       = 4'h0,
    SDCMD_DESEL     = 4'h1,
    SDCMD_MRS       = 4'h2,
    SDCMD_REF       = 4'h3,
    SDCMD_ACT       = 4'h4,
    SDCMD_RD        = 4'h5,
    SDCMD_WR        = 4'h6,
    SDCMD_PRE       = 4'h7,
    SDCMD_ILLEGAL   = 4'h8
  } sdcmd_cmd_t;

  // Power state of the device
  typedef enum logic [2:0] {
    SDCMD_ST_IDLE   = 3'h0,
    SDCMD_ST_ACTIVE = 3'h1,
    SDCMD_ST_PPD    = 3'h2,
    SDCMD_ST_APD    = 3'h3,
    SDCMD_ST_SREF   = 3'h4,
    SDCMD_ST_SRX    = 3'h5
  } sdcmd_pstate_t;

endpackage

// ===== verilog/sdcmd_dec_if.sv
// Purpose: Carries one decoded command between decoder and top
// Assumes: Single clock
// Notes:   Pure combinational carrier

`timescale 1ns/100ps

interface sdcmd_dec_if;
  import sdcmd_pkg::*;
  logic                cs_n;
  logic                ras_n;
  logic                cas_n;
  logic                we_n;
  logic [ADDR_W-1:0]   addr;
  sdcmd_cmd_t          cmd;
  logic                a10;
  modport dec (input cs_n, ras_n, cas_n, we_n, addr, output cmd, a10);
  modport use_side (output cs_n, ras_n, cas_n, we_n, addr, input cmd, a10);
endinterface

// ===== verilog/sdcmd_pin_decode.sv
// Purpose: Decodes the four command pins into one command code
// Assumes: Pins valid at the sampling edge
// Notes:   Combinational only

`timescale 1ns/100ps

module sdcmd_pin_decode
  import sdcmd_pkg::*;
(
  // Command carrier
  sdcmd_dec_if.dec d
);

  // Truth-table decode
  always_comb begin
    d.a10 = d.addr[A10_POS];
    if (d.cs_n) begin
      d.cmd = SDCMD_DESEL;
    end else begin
      unique case ({d.ras_n, d.cas_n, d.we_n})
        3'h0: d.cmd = SDCMD_MRS;
        3'h1: d.cmd = SDCMD_REF;
        3'h2: d.cmd = SDCMD_PRE;
        3'h3: d.cmd = SDCMD_ACT;
        3'h4: d.cmd = SDCMD_WR;
        3'h5: d.cmd = SDCMD_RD;
        3'h7: d.cmd = SDCMD_NOP;
        default: d.cmd = SDCMD_ILLEGAL;
      endcase
    end
  end

endmodule

// ===== verilog/sdcmd_bank_track.sv
// Purpose: Tracks which banks hold an open row
// Assumes: Commands are already decoded
// Notes:   Auto-precharge closes the bank when the burst ends

`timescale 1ns/100ps

module sdcmd_bank_track
  import sdcmd_pkg::*;
#(
  parameter int NB = NUM_BANKS
)
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Commands
  input  wire logic              act_pulse,
  input  wire logic              pre_pulse,
  input  wire logic              pre_all,
  input  wire logic              ap_done,
  input  wire logic [BANK_W-1:0] bank,
  input  wire logic [BANK_W-1:0] ap_bank,
  // State
  output logic [NB-1:0]          open_reg
);

  initial begin
    if (NB != (1 << BANK_W)) $error("bank count must match bank address width");
  end

  typedef struct packed { logic [NB-1:0] open; } sdcmd_bt_t;
  sdcmd_bt_t s_reg;
  sdcmd_bt_t s_next;

  // Open/close update
  always_comb begin
    s_next = s_reg;
    if (ap_done) s_next.open[ap_bank] = 1'b0;
    if (pre_pulse) begin
      if (pre_all) s_next.open = '0;
      else s_next.open[bank] = 1'b0;
    end
    if (act_pulse) s_next.open[bank] = 1'b1;
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) s_reg <= '0;
    else s_reg <= s_next;
  end

  assign open_reg = s_reg.open;

endmodule

// ===== bench/sdcmd_ctrl_model.sv
// Purpose: Controller model that drives the command and clock-enable pins
// Assumes: Pins change just after the rising edge, one command per edge
// Notes:   Released address and bank lines toggle so stale values cannot pass

`timescale 1ns/100ps

module sdcmd_ctrl_model
  import sdcmd_pkg::*;
(
  // Clock
  input  wire logic              clk_sys,
  // Command pins
  output logic                   cke,
  output logic                   cs_n,
  output logic                   ras_n,
  output logic                   cas_n,
  output logic                   we_n,
  output logic [BANK_W-1:0]      ba,
  output logic [ADDR_W-1:0]      addr,
  // Termination and mask
  output logic                   odt,
  output logic                   dm
);
  logic cke_v;
  logic odt_v;
  logic dm_v;

  // Defined levels from time zero
  initial begin
    {cke, cke_v, odt, odt_v, dm, dm_v} = 6'h00;
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    ba = 2'h0;
    addr = 13'h0000;
  end

  // One command for one edge; termination always driven to a level
  task automatic cmd(input logic [3:0] p, input logic [BANK_W-1:0] b,
                     input logic [ADDR_W-1:0] a);
    @(posedge clk_sys);
    {cs_n, ras_n, cas_n, we_n} <= p;
    ba <= b;
    addr <= a;
    cke <= cke_v;
    odt <= odt_v;
    dm <= dm_v;
  endtask

  // Quiet cycles with the released lines toggling
  task automatic idle(input int n);
    repeat (n) cmd(4'h7, ~ba, ~addr);
  endtask

  // Enable change beside a command, then held for two quiet edges
  task automatic cke_to(input logic v, input logic [3:0] p);
    cke_v = v;
    cmd(p, ~ba, ~addr);
    idle(2);
  endtask
endmodule

// ===== bench/tb.sv
// Purpose: Self-checking bench of the command and clock-enable decoder
// Assumes: Controller model drives all pins; event counters watch pulses
// Notes:   Exit intervals shortened through the top parameters

`timescale 1ns/100ps

module tb;
  import sdcmd_pkg::*;
  localparam int NR = 6;
  localparam int RD = 8;
  localparam int BC = BURST_CYCLES;
  localparam logic [3:0] C_NOP = 4'h7;
  localparam logic [3:0] C_DES = 4'h8;
  localparam logic [3:0] C_MRS = 4'h0;
  localparam logic [3:0] C_REF = 4'h1;
  localparam logic [3:0] C_ACT = 4'h3;
  localparam logic [3:0] C_RD  = 4'h5;
  localparam logic [3:0] C_WR  = 4'h4;
  localparam logic [3:0] C_PRE = 4'h2;
  localparam logic [3:0] C_BAD = 4'h6;

  logic                  clk_sys;
  logic                  rst;
  logic                  cke, cs_n, ras_n, cas_n, we_n, odt, dm;
  logic [BANK_W-1:0]     ba, mrs_sel_reg, bank_reg;
  logic [ADDR_W-1:0]     addr, mrs_opcode_reg, act_row_reg;
  logic                  mrs_pulse_reg, refresh_pulse_reg, act_pulse_reg, rd_pulse_reg;
  logic                  wr_pulse_reg, auto_pre_reg, pre_pulse_reg, pre_all_reg;
  logic                  write_beat_en_reg, burst_busy_reg, odt_active_reg;
  logic                  read_allowed_reg, illegal_cmd_reg;
  logic [NUM_BANKS-1:0]  bank_open_reg;
  sdcmd_pstate_t         pstate_reg;
  int                    cnt [10];
  int                    e [10];
  int                    err_count;
  int                    checked;

  // ****************************************
  // Clock, model and design
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  sdcmd_ctrl_model ctrl_u (.clk_sys(clk_sys), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .odt(odt), .dm(dm));

  sdcmd_top #(.NONREAD_CLKS(NR), .READ_CLKS(RD)) dut_u (.clk_sys(clk_sys), .rst(rst),
    .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
    .addr(addr), .odt(odt), .dm(dm), .mrs_pulse_reg(mrs_pulse_reg),
    .mrs_sel_reg(mrs_sel_reg), .mrs_opcode_reg(mrs_opcode_reg),
    .refresh_pulse_reg(refresh_pulse_reg), .act_pulse_reg(act_pulse_reg),
    .act_row_reg(act_row_reg), .rd_pulse_reg(rd_pulse_reg), .wr_pulse_reg(wr_pulse_reg),
    .auto_pre_reg(auto_pre_reg), .pre_pulse_reg(pre_pulse_reg), .pre_all_reg(pre_all_reg),
    .bank_reg(bank_reg), .write_beat_en_reg(write_beat_en_reg),
    .bank_open_reg(bank_open_reg), .burst_busy_reg(burst_busy_reg),
    .pstate_reg(pstate_reg), .odt_active_reg(odt_active_reg),
    .read_allowed_reg(read_allowed_reg), .illegal_cmd_reg(illegal_cmd_reg));

  // Counts every cycle each event output is high
  wire [9:0] ev = {pstate_reg === SDCMD_ST_SRX, burst_busy_reg, write_beat_en_reg,
                   illegal_cmd_reg, pre_pulse_reg, wr_pulse_reg, rd_pulse_reg,
                   act_pulse_reg, refresh_pulse_reg, mrs_pulse_reg};
  always @(posedge clk_sys) begin
    for (int i = 0; i < 10; i++) begin
      if (ev[i] === 1'b1) cnt[i] <= cnt[i] + 1;
    end
  end

  // ****************************************
  // Compare and closing tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    #1;
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic st(input sdcmd_pstate_t s);
    chk(16'(pstate_reg), 16'(s));
  endtask

  // Quiet gap, then each event count except the exit-state one against its expectation
  task automatic step();
    ctrl_u.idle(5);
    for (int i = 0; i < 9; i++) begin
      chk(16'(cnt[i]), 16'(e[i]));
    end
  endtask

  task automatic end_of_test();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (3000) @(posedge clk_sys);
    err_count++;
    end_of_test();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    ctrl_u.cke_to(1'b1, C_NOP);
    step();
    st(SDCMD_ST_IDLE);
    chk(16'(read_allowed_reg), 16'h0001);
    // Mode register writes to every selector
    for (int b = 0; b < 4; b++) begin
      ctrl_u.cmd(C_MRS, 2'(b), 13'(16'h0A50 + b));
      e[0]++;
      step();
      chk(16'(mrs_sel_reg), 16'(b));
      chk(16'(mrs_opcode_reg), 16'h0A50 + 16'(b));
    end
    ctrl_u.cmd(C_DES, 2'h3, 13'h1FFF);
    step();
    ctrl_u.cmd(C_BAD, 2'h0, 13'h0000);
    e[6]++;
    step();
    // Row open, writes and a self-closing read
    ctrl_u.cmd(C_ACT, 2'h1, 13'h1234);
    e[2]++;
    step();
    chk(16'(act_row_reg), 16'h1234);
    chk(16'(bank_open_reg), 16'h0002);
    st(SDCMD_ST_ACTIVE);
    ctrl_u.cmd(C_WR, 2'h1, 13'h0008);
    e[4]++;
    e[7] += BC;
    e[8] += BC;
    step();
    chk(16'(auto_pre_reg), 16'h0000);
    ctrl_u.dm_v = 1'b1;
    ctrl_u.cmd(C_WR, 2'h1, 13'h0010);
    e[4]++;
    e[8] += BC;
    step();
    ctrl_u.dm_v = 1'b0;
    ctrl_u.cmd(C_RD, 2'h1, 13'h0400);
    e[3]++;
    e[8] += BC;
    step();
    chk(16'(auto_pre_reg), 16'h0001);
    chk(16'(bank_open_reg), 16'h0000);
    // Single-bank and all-bank precharge
    ctrl_u.cmd(C_ACT, 2'h0, 13'h0011);
    ctrl_u.cmd(C_ACT, 2'h2, 13'h0022);
    ctrl_u.cmd(C_PRE, 2'h0, 13'h0000);
    e[2] += 2;
    e[5]++;
    step();
    chk(16'(pre_all_reg), 16'h0000);
    chk(16'(bank_open_reg), 16'h0004);
    chk(16'(bank_reg), 16'h0000);
    ctrl_u.cmd(C_PRE, 2'h3, 13'h0400);
    e[5]++;
    step();
    chk(16'(pre_all_reg), 16'h0001);
    chk(16'(bank_open_reg), 16'h0000);
    // Active power-down, commands and termination ignored
    ctrl_u.cmd(C_ACT, 2'h3, 13'h0055);
    e[2]++;
    step();
    ctrl_u.cke_to(1'b0, C_NOP);
    st(SDCMD_ST_APD);
    ctrl_u.odt_v = 1'b1;
    ctrl_u.cmd(C_MRS, 2'h0, 13'h0000);
    ctrl_u.cmd(C_REF, 2'h0, 13'h0000);
    step();
    st(SDCMD_ST_APD);
    ctrl_u.cke_to(1'b1, C_DES);
    step();
    st(SDCMD_ST_ACTIVE);
    // Precharge power-down
    ctrl_u.odt_v = 1'b0;
    ctrl_u.cmd(C_PRE, 2'h0, 13'h0400);
    e[5]++;
    step();
    ctrl_u.cke_to(1'b0, C_NOP);
    ctrl_u.cmd(C_ACT, 2'h1, 13'h0001);
    step();
    st(SDCMD_ST_PPD);
    ctrl_u.cke_to(1'b1, C_NOP);
    step();
    st(SDCMD_ST_IDLE);
    // Loop reset write after leaving precharge power-down, termination still off
    ctrl_u.cmd(C_MRS, 2'h1, 13'h0100);
    e[0]++;
    step();
    chk(16'(mrs_sel_reg), 16'h0001);
    // Refresh, then self-refresh entry and exit
    ctrl_u.cmd(C_REF, 2'h0, 13'h0000);
    e[1]++;
    ctrl_u.odt_v = 1'b1;
    step();
    chk(16'(odt_active_reg), 16'h0001);
    ctrl_u.cke_to(1'b0, C_REF);
    step();
    st(SDCMD_ST_SREF);
    chk(16'(odt_active_reg), 16'h0000);
    chk(16'(read_allowed_reg), 16'h0000);
    ctrl_u.odt_v = 1'b0;
    ctrl_u.cke_to(1'b1, C_NOP);
    ctrl_u.cmd(C_ACT, 2'h2, 13'h0002);
    e[6]++;
    chk(16'(read_allowed_reg), 16'h0000);
    ctrl_u.idle(RD);
    step();
    chk(16'(cnt[9] >= NR && cnt[9] <= NR + 1), 16'h0001);
    st(SDCMD_ST_IDLE);
    chk(16'(read_allowed_reg), 16'h0001);
    end_of_test();
  end
endmodule
